// ---- rtl/fault_speed_supervisor.v ----
// Fault handling, speed command selection and register file of the motor supervisor.
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_regs.vh"

module fault_speed_supervisor #(
   parameter integer LOCK_OFF_CYCLES = `LOCK_OFF_CYCLES,
   parameter integer LOCK_METHODS    = 6,
   parameter integer DUTY_W          = 9
) (
   input  wire                    mclk,
   input  wire                    resetn,
   input  wire                    temp_over,
   input  wire                    temp_hot,
   input  wire                    supply_low_fall,
   input  wire                    supply_high_rise,
   input  wire                    buck_uv,
   input  wire                    pump_uv,
   input  wire                    ldo33_uv,
   input  wire                    overcurrent_in,
   input  wire [LOCK_METHODS-1:0] lock_detect,
   input  wire                    dir_pin,
   input  wire                    commutate,
   input  wire [DUTY_W-1:0]       pulse_duty,
   input  wire [DUTY_W-1:0]       analog_duty,
   input  wire [DUTY_W-1:0]       limit_duty,
   input  wire                    wake,
   input  wire                    nv_valid,
   input  wire [DUTY_W-1:0]       nv_speed,
   input  wire [4:0]              nv_control,
   input  wire [DUTY_W-1:0]       nv_limits,
   input  wire [11:0]             supply_adc,
   input  wire [11:0]             current_adc,
   input  wire                    reg_wr,
   input  wire                    reg_rd,
   input  wire [7:0]              reg_addr,
   input  wire [15:0]             reg_wdata,
   output reg  [15:0]             reg_rdata,
   output wire                    nv_load_req,
   output reg                     stage_enable,
   output reg                     phases_float,
   output reg                     dir_out,
   output reg                     tach_out,
   output reg  [DUTY_W-1:0]       output_peak_duty
);

// ---------------------------------------------------------------
// Input synchronisers
// ---------------------------------------------------------------
// Commutate, duty and measurement inputs are already synchronous and skip these flops.
localparam integer NSYNC = 9 + LOCK_METHODS;
wire [NSYNC-1:0] raw_in = {lock_detect, dir_pin, overcurrent_in, ldo33_uv, pump_uv,
                           buck_uv, supply_high_rise, supply_low_fall, temp_hot, temp_over};
reg  [NSYNC-1:0] sync1_r;
reg  [NSYNC-1:0] sync2_r;

always @(posedge mclk) begin
   if (!resetn) begin
      sync1_r <= {NSYNC{1'b0}};
      sync2_r <= {NSYNC{1'b0}};
   end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
   end
end

wire t_over = sync2_r[0];
wire t_hot  = sync2_r[1];
wire s_fall = sync2_r[2];
wire s_rise = sync2_r[3];
wire uv_aux = sync2_r[4] | sync2_r[5] | sync2_r[6];
wire oc     = sync2_r[7];
wire dir_s  = sync2_r[8];
wire [LOCK_METHODS-1:0] lock_s = sync2_r[NSYNC-1:9];

// ---------------------------------------------------------------
// Thermal and supply lockout
// ---------------------------------------------------------------
// The thermal comparator is assumed to carry the hysteresis itself, so it
// drops only once the die is below the threshold less the hysteresis.
// The thermal and main supply flags add one flop, so those stops land a cycle
// later than overcurrent, lock and auxiliary undervoltage stops.
reg thermal_r;
reg uvlo_r;

always @(posedge mclk) begin
   if (!resetn) begin
      thermal_r <= 1'b0;
      uvlo_r    <= 1'b1;
   end else begin
      thermal_r <= t_over;
      if (s_fall) begin
         uvlo_r <= 1'b1;
      end else if (s_rise) begin
         uvlo_r <= 1'b0;
      end
   end
end

// ---------------------------------------------------------------
// Overcurrent and lock protection cycle
// ---------------------------------------------------------------
// Overcurrent outranks lock, so a shorted phase is never reported as a stall.
localparam [1:0] ST_RUN  = 2'h0;
localparam [1:0] ST_OC   = 2'h1;
localparam [1:0] ST_LOCK = 2'h2;

reg [1:0]              state_r;
reg [1:0]              state_nxt;
reg [31:0]             wait_r;
reg                    oc_flag_r;
reg [LOCK_METHODS-1:0] lock_cause_r;

wire wait_done = (wait_r == 32'h0000_0000);

always @* begin
   state_nxt = state_r;
   case (state_r)
      ST_RUN: begin
         if (oc) begin
            state_nxt = ST_OC;
         end else if (|lock_s) begin
            state_nxt = ST_LOCK;
         end
      end
      ST_OC: begin
         if (wait_done) begin
            state_nxt = ST_RUN;
         end
      end
      ST_LOCK: begin
         if (wait_done) begin
            state_nxt = ST_RUN;
         end
      end
      default: begin
         state_nxt = ST_RUN;
      end
   endcase
end

always @(posedge mclk) begin
   if (!resetn) begin
      state_r      <= ST_RUN;
      wait_r       <= 32'h0000_0000;
      oc_flag_r    <= 1'b0;
      lock_cause_r <= {LOCK_METHODS{1'b0}};
   end else begin
      state_r <= state_nxt;
      if (state_r == ST_RUN && state_nxt != ST_RUN) begin
         wait_r <= LOCK_OFF_CYCLES - 1;
      end else if (!wait_done) begin
         wait_r <= wait_r - 32'h0000_0001;
      end
      if (state_r == ST_RUN && oc) begin
         oc_flag_r <= 1'b1;
      end else if (state_r == ST_OC && wait_done) begin
         oc_flag_r <= 1'b0;
      end
      // A lock seen again after the restart re-enters the stop state from run.
      if (state_r == ST_RUN && !oc && (|lock_s)) begin
         lock_cause_r <= lock_s;
      end else if (state_r == ST_RUN && !(|lock_s)) begin
         lock_cause_r <= {LOCK_METHODS{1'b0}};
      end
   end
end

// Lock stop is taken from the synchronised detector in the same cycle, so
// the stage drops with no extra delay beyond the synchroniser.
wire lock_now = (state_r == ST_RUN) & ~oc & (|lock_s);
wire stop_any = thermal_r | uvlo_r | uv_aux | (state_r != ST_RUN) | oc | lock_now;

// ---------------------------------------------------------------
// Registers and nonvolatile load
// ---------------------------------------------------------------
reg [DUTY_W-1:0] speed_r;
reg [4:0]        control_r;
reg [DUTY_W-1:0] limits_r;
reg              load_pend_r;
reg [11:0]       supply_meas_r;
reg [11:0]       current_meas_r;
reg [15:0]       sample_cnt_r;

assign nv_load_req = load_pend_r;

wire reg_mode = control_r[`CTL_REG_MODE];

always @(posedge mclk) begin
   if (!resetn) begin
      speed_r     <= `RST_SPEED_CMD;
      control_r   <= `RST_CONTROL;
      limits_r    <= `RST_LIMITS;
      load_pend_r <= 1'b1;
   end else begin
      if (load_pend_r && nv_valid && !reg_mode) begin
         speed_r     <= nv_speed;
         control_r   <= nv_control;
         limits_r    <= nv_limits;
         load_pend_r <= 1'b0;
      end else if (load_pend_r && nv_valid) begin
         load_pend_r <= 1'b0;
      end else if (wake) begin
         load_pend_r <= 1'b1;
      end
      // A write in the load cycle is dropped, so the stored copy is not torn.
      if (reg_wr && !(load_pend_r && nv_valid)) begin
         if (reg_addr == `OFS_SPEED_CMD) begin
            speed_r <= reg_wdata[DUTY_W-1:0];
         end else if (reg_addr == `OFS_CONTROL) begin
            control_r <= reg_wdata[4:0];
         end else if (reg_addr == `OFS_LIMITS) begin
            limits_r <= reg_wdata[DUTY_W-1:0];
         end
      end
   end
end

// The supply is sampled on a slow tick; the current follows every cycle.
wire [31:0] sample_load = `SAMPLE_CYCLES - 1;

always @(posedge mclk) begin
   if (!resetn) begin
      supply_meas_r  <= 12'h000;
      current_meas_r <= 12'h000;
      sample_cnt_r   <= 16'h0000;
   end else begin
      current_meas_r <= current_adc;
      if (sample_cnt_r == 16'h0000) begin
         sample_cnt_r  <= sample_load[15:0];
         supply_meas_r <= supply_adc;
      end else begin
         sample_cnt_r <= sample_cnt_r - 16'h0001;
      end
   end
end

wire [15:0] fault_word;
assign fault_word[`BIT_THERMAL]     = thermal_r;
assign fault_word[`BIT_HOT_WARN]    = t_hot;
assign fault_word[`BIT_UV_MAIN]     = uvlo_r;
assign fault_word[`BIT_UV_AUX]      = uv_aux;
assign fault_word[`BIT_OVERCURRENT] = oc_flag_r;
assign fault_word[`BIT_LOCK_HI:`BIT_LOCK_LO] = lock_cause_r;
assign fault_word[4:0] = 5'h00;

always @(posedge mclk) begin
   if (!resetn) begin
      reg_rdata <= 16'h0000;
   end else if (reg_rd) begin
      if (reg_addr == `OFS_FAULT_FLAGS) begin
         reg_rdata <= fault_word;
      end else if (reg_addr == `OFS_SPEED_CMD) begin
         reg_rdata <= {{(16-DUTY_W){1'b0}}, speed_r};
      end else if (reg_addr == `OFS_CONTROL) begin
         reg_rdata <= {11'h000, control_r};
      end else if (reg_addr == `OFS_LIMITS) begin
         reg_rdata <= {{(16-DUTY_W){1'b0}}, limits_r};
      end else if (reg_addr == `OFS_SUPPLY_MEAS) begin
         reg_rdata <= {4'h0, supply_meas_r};
      end else if (reg_addr == `OFS_CURRENT_MEAS) begin
         reg_rdata <= {4'h0, current_meas_r};
      end else begin
         reg_rdata <= 16'h0000;
      end
   end
end

// ---------------------------------------------------------------
// Speed command and output duty
// ---------------------------------------------------------------
wire [1:0] src_sel = control_r[`CTL_SRC_HI:`CTL_SRC_LO];
wire [1:0] min_sel = control_r[`CTL_MIN_HI:`CTL_MIN_LO];
reg  [DUTY_W-1:0] cmd;
reg  [DUTY_W-1:0] pulse_lim;
reg  [DUTY_W-1:0] duty_nxt;

always @* begin
   // Scaling adds half the input, with the minimum's set bits masked off, to the minimum.
   case (min_sel)
      `MIN_CLAMP:      pulse_lim = (pulse_duty < limits_r) ? limits_r : pulse_duty;
      `MIN_ZERO_BELOW: pulse_lim = (pulse_duty < limits_r) ? {DUTY_W{1'b0}} : pulse_duty;
      `MIN_SCALE:      pulse_lim = limits_r + ((pulse_duty >> 1) & ~limits_r);
      default:         pulse_lim = pulse_duty;
   endcase
   case (src_sel)
      `SRC_ANALOG: cmd = analog_duty;
      `SRC_SERIAL: cmd = speed_r;
      default:     cmd = pulse_lim;
   endcase
   // The ceiling is the lowest of the surge, current and loop limits, formed
   // outside the block; only the final minimum is taken here.
   duty_nxt = (limit_duty < cmd) ? limit_duty : cmd;
end

// Commutation is taken as synchronous to mclk; the delay flop resets low,
// the strobe's idle level, so no false toggle follows reset.
reg comm_d_r;

always @(posedge mclk) begin
   if (!resetn) begin
      output_peak_duty <= {DUTY_W{1'b0}};
      stage_enable     <= 1'b0;
      phases_float     <= 1'b1;
      dir_out          <= 1'b0;
      tach_out         <= 1'b0;
      comm_d_r         <= 1'b0;
   end else begin
      output_peak_duty <= stop_any ? {DUTY_W{1'b0}} : duty_nxt;
      stage_enable     <= ~stop_any;
      phases_float     <= stop_any;
      dir_out          <= dir_s;
      comm_d_r         <= commutate;
      if (commutate && !comm_d_r) begin
         tach_out <= ~tach_out;
      end
   end
end

endmodule // fault_speed_supervisor
`default_nettype wire

// ---- rtl/supervisor_regs.vh ----
// Register offsets, field positions, reset values and timing counts of the supervisor.
`ifndef SUPERVISOR_REGS_VH
`define SUPERVISOR_REGS_VH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define OFS_FAULT_FLAGS   8'h00
`define OFS_SPEED_CMD     8'h01
`define OFS_CONTROL       8'h02
`define OFS_LIMITS        8'h03
`define OFS_SUPPLY_MEAS   8'h04
`define OFS_CURRENT_MEAS  8'h05
// ---------------------------------------------------------------
// Fault flag bit positions
// ---------------------------------------------------------------
`define BIT_THERMAL       15
`define BIT_HOT_WARN      14
`define BIT_UV_MAIN       13
`define BIT_UV_AUX        12
`define BIT_OVERCURRENT   11
`define BIT_LOCK_HI       10
`define BIT_LOCK_LO       5
// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define CTL_REG_MODE      0
`define CTL_SRC_LO        1
`define CTL_SRC_HI        2
`define CTL_MIN_LO        3
`define CTL_MIN_HI        4
// ---------------------------------------------------------------
// Speed source and minimum duty encodings
// ---------------------------------------------------------------
`define SRC_PULSE         2'h0
`define SRC_ANALOG        2'h1
`define SRC_SERIAL        2'h2
`define MIN_NONE          2'h0
`define MIN_CLAMP         2'h1
`define MIN_ZERO_BELOW    2'h2
`define MIN_SCALE         2'h3
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RST_SPEED_CMD     9'h000
`define RST_CONTROL       5'h00
`define RST_LIMITS        9'h040
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_HZ            20000000
`define LOCK_OFF_S        5
`define LOCK_OFF_CYCLES   (`LOCK_OFF_S * `CLK_HZ)
`define SAMPLE_US         100
`define SAMPLE_CYCLES     ((`SAMPLE_US * `CLK_HZ) / 1000000)
`endif

// ---- tb/host_model.sv ----
// Register host model that drives the supervisor's strobe port.
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input  wire logic        mclk,
   output var  logic        reg_wr,
   output var  logic        reg_rd,
   output var  logic [7:0]  reg_addr,
   output var  logic [15:0] reg_wdata,
   input  wire logic [15:0] reg_rdata
);
   initial begin
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
   end
   // Released lines show the inverse, so a stale value never matches by luck.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge mclk);
      {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(negedge mclk);
      {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(negedge mclk);
      {reg_addr, reg_rd} = {a, 1'b1};
      @(negedge mclk);
      {reg_addr, reg_rd} = {~a, 1'b0};
      d = reg_rdata;
   endtask
endmodule // host_model
`default_nettype wire

// ---- tb/supervisor_monitor.sv ----
// Concurrent checks on the ports of the fault and speed supervisor.
`timescale 1ns/100ps
`default_nettype none
module supervisor_monitor (
   input wire logic        mclk,
   input wire logic        resetn,
   input wire logic        temp_over,
   input wire logic        temp_hot,
   input wire logic        supply_low_fall,
   input wire logic        buck_uv,
   input wire logic        pump_uv,
   input wire logic        ldo33_uv,
   input wire logic        overcurrent_in,
   input wire logic [5:0]  lock_detect,
   input wire logic        dir_pin,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_addr,
   input wire logic [8:0]  limit_duty,
   input wire logic [11:0] current_adc,
   input wire logic [15:0] reg_rdata,
   input wire logic        stage_enable,
   input wire logic        phases_float,
   input wire logic        dir_out,
   input wire logic [8:0]  output_peak_duty
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   wire rd_fault = reg_rd && (reg_addr == 8'h00);
   wire any_aux = buck_uv || pump_uv || ldo33_uv;
   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_oc_float: assert property ($rose(overcurrent_in) |-> ##[2:4] (!stage_enable && phases_float))
      else $error("overcurrent did not float the phases");
   a_lock_stop: assert property ($rose(|lock_detect) |-> ##[2:4] !stage_enable)
      else $error("lock did not stop the stage");
   a_heat_stop: assert property (temp_over[*5] |-> !stage_enable)
      else $error("stage running while hot");
   a_uv_stop: assert property (supply_low_fall[*5] |-> !stage_enable)
      else $error("stage running in undervoltage");
   a_heat_bit: assert property (temp_over[*4] ##0 rd_fault |=> reg_rdata[15])
      else $error("thermal flag clear during shutdown");
   a_warn_bit: assert property (temp_hot[*4] ##0 rd_fault |=> reg_rdata[14])
      else $error("warning flag clear while hot");
   a_aux_bit: assert property (any_aux[*4] ##0 rd_fault |=> reg_rdata[12])
      else $error("auxiliary undervoltage flag clear");
   a_oc_bit: assert property ($rose(overcurrent_in) ##4 rd_fault |=> reg_rdata[11])
      else $error("overcurrent flag clear");
   a_dir_follow: assert property ($stable(dir_pin)[*6] |-> dir_out == dir_pin)
      else $error("direction output does not follow pin");
   a_duty_cap: assert property ($stable(limit_duty)[*4] |-> output_peak_duty <= limit_duty)
      else $error("duty above limiter ceiling");
   a_meas_read: assert property ($stable(current_adc)[*4] ##0 (reg_rd && reg_addr == 8'h05)
      |=> reg_rdata == {4'h0, $past(current_adc)})
      else $error("current measurement read wrong");
   cover property ($rose(overcurrent_in));
   cover property ($rose(|lock_detect));
   cover property ($fell(stage_enable));
endmodule // supervisor_monitor
`default_nettype wire

// ---- tb/tb_fault_speed_supervisor.sv ----
// Self-checking bench for the fault and speed supervisor.
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_regs.vh"
module tb_fault_speed_supervisor;
   localparam integer LOCK = 20;
   logic mclk, resetn, temp_over, temp_hot, supply_low_fall, supply_high_rise;
   logic buck_uv, pump_uv, ldo33_uv, overcurrent_in, dir_pin, commutate, wake;
   logic nv_valid, reg_wr, reg_rd, nv_load_req, stage_enable, phases_float;
   logic dir_out, tach_out;
   logic [5:0]  lock_detect;
   logic [4:0]  nv_control;
   logic [7:0]  reg_addr;
   logic [8:0]  pulse_duty, analog_duty, limit_duty, nv_speed, nv_limits, output_peak_duty;
   logic [11:0] supply_adc, current_adc;
   logic [15:0] reg_wdata, reg_rdata;
   int num_errors, checks_done, waited;
   fault_speed_supervisor #(.LOCK_OFF_CYCLES(LOCK)) fault_speed_supervisor_inst (.*);
   host_model host_model_inst (.*);
   always #25 mclk = ~mclk;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] exp);
      logic [15:0] d;
      host_model_inst.rd(a, d);
      chk(d & m, exp);
   endtask
   function automatic logic [15:0] pick(input int s);
      case (s)
         0: pick = {15'h0, stage_enable};
         1: pick = {7'h0, output_peak_duty};
         default: pick = {15'h0, nv_load_req};
      endcase
   endfunction
   // Bounded wait; running out of cycles shows up as a mismatch.
   task automatic wait_on(input int s, input logic [15:0] exp);
      waited = 0;
      while (pick(s) !== exp && waited < 400) begin
         @(negedge mclk);
         waited++;
      end
      chk(pick(s), exp);
   endtask
   task automatic final_report;
      $display("TB: errors=%0d checks=%0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      {mclk, resetn, temp_over, temp_hot, supply_low_fall, buck_uv, pump_uv} = '0;
      {ldo33_uv, overcurrent_in, dir_pin, commutate, wake, nv_valid, lock_detect} = '0;
      {supply_high_rise, supply_adc, current_adc} = {1'b1, 12'h800, 12'hABC};
      {pulse_duty, analog_duty, limit_duty} = {9'h0A0, 9'h150, 9'h1FF};
      {nv_speed, nv_control, nv_limits} = {9'h030, 5'h04, 9'h020};
      repeat (8) @(negedge mclk);
      resetn = 1'b1;
      nv_valid = 1'b1;
      wait_on(2, 16'h0000);
      rchk(`OFS_SPEED_CMD, 16'hFFFF, 16'h0030);
      rchk(`OFS_CONTROL, 16'hFFFF, 16'h0004);
      rchk(`OFS_LIMITS, 16'hFFFF, 16'h0020);
      host_model_inst.wr(`OFS_FAULT_FLAGS, 16'hFFFF);
      rchk(`OFS_FAULT_FLAGS, 16'hFFFF, 16'h0000);
      rchk(8'h3C, 16'hFFFF, 16'h0000);
      rchk(`OFS_CURRENT_MEAS, 16'hFFFF, 16'h0ABC);
      rchk(`OFS_SUPPLY_MEAS, 16'hFFFF, 16'h0800);
      host_model_inst.wr(`OFS_CONTROL, 16'h0005);
      host_model_inst.wr(`OFS_SPEED_CMD, 16'h0120);
      host_model_inst.wr(`OFS_LIMITS, 16'h0040);
      @(negedge mclk) wake = 1'b1;
      @(negedge mclk) wake = 1'b0;
      rchk(`OFS_SPEED_CMD, 16'hFFFF, 16'h0120);
      for (int s = 0; s < 3; s++) begin
         host_model_inst.wr(`OFS_CONTROL, {11'h0, `MIN_NONE, s[1:0], 1'b1});
         wait_on(1, s == 0 ? 16'h00A0 : s == 1 ? 16'h0150 : 16'h0120);
      end
      pulse_duty = 9'h010;
      for (int m = 1; m < 3; m++) begin
         host_model_inst.wr(`OFS_CONTROL, {11'h0, m[1:0], `SRC_PULSE, 1'b1});
         wait_on(1, m == 1 ? 16'h0040 : 16'h0000);
      end
      host_model_inst.wr(`OFS_CONTROL, {11'h0, `MIN_NONE, `SRC_SERIAL, 1'b1});
      limit_duty = 9'h080;
      wait_on(1, 16'h0080);
      limit_duty = 9'h1FF;
      wait_on(0, 16'h0001);
      {supply_high_rise, supply_low_fall} = 2'b01;
      wait_on(0, 16'h0000);
      repeat (4) @(negedge mclk);
      supply_low_fall = 1'b0;
      repeat (10) @(negedge mclk);
      chk({15'h0, stage_enable}, 16'h0000);
      supply_high_rise = 1'b1;
      wait_on(0, 16'h0001);
      temp_hot = 1'b1;
      repeat (4) @(negedge mclk);
      rchk(`OFS_FAULT_FLAGS, 16'h4000, 16'h4000);
      chk({15'h0, stage_enable}, 16'h0001);
      temp_over = 1'b1;
      wait_on(0, 16'h0000);
      rchk(`OFS_FAULT_FLAGS, 16'h8000, 16'h8000);
      {temp_over, temp_hot} = 2'b00;
      wait_on(0, 16'h0001);
      buck_uv = 1'b1;
      wait_on(0, 16'h0000);
      rchk(`OFS_FAULT_FLAGS, 16'h1000, 16'h1000);
      buck_uv = 1'b0;
      wait_on(0, 16'h0001);
      overcurrent_in = 1'b1;
      wait_on(0, 16'h0000);
      overcurrent_in = 1'b0;
      chk({15'h0, phases_float}, 16'h0001);
      rchk(`OFS_FAULT_FLAGS, 16'h0800, 16'h0800);
      wait_on(0, 16'h0001);
      chk({15'h0, waited + 2 >= LOCK - 3 && waited + 2 <= LOCK + 4}, 16'h0001);
      for (int i = 0; i < 6; i++) begin
         lock_detect = 6'h01 << i;
         wait_on(0, 16'h0000);
         rchk(`OFS_FAULT_FLAGS, 16'h07E0, 16'h0020 << i);
         if (i == 0) begin
            // The detector drops while the stage is off and sees the stall again on restart.
            lock_detect = 6'h00;
            wait_on(0, 16'h0001);
            lock_detect = 6'h01;
            wait_on(0, 16'h0000);
            rchk(`OFS_FAULT_FLAGS, 16'h07E0, 16'h0020);
         end
         lock_detect = 6'h00;
         wait_on(0, 16'h0001);
      end
      @(negedge mclk) commutate = 1'b1;
      @(negedge mclk) commutate = 1'b0;
      chk({15'h0, tach_out}, 16'h0001);
      @(negedge mclk) commutate = 1'b1;
      repeat (3) @(negedge mclk);
      chk({15'h0, tach_out}, 16'h0000);
      dir_pin = 1'b1;
      repeat (4) @(negedge mclk);
      chk({15'h0, dir_out}, 16'h0001);
      final_report();
   end
endmodule // tb_fault_speed_supervisor
bind fault_speed_supervisor supervisor_monitor supervisor_monitor_inst (.*);
`default_nettype wire
